// ---- rtl/i2r_pkg.sv ----
package i2r_pkg;

	// Register byte addresses on APB.
	localparam logic [31:0] ADDR_CLOCK_SETUP   = 32'h8082_0004;
	localparam logic [31:0] ADDR_CH0_LEFT      = 32'h8082_0040;
	localparam logic [31:0] ADDR_CH0_RIGHT     = 32'h8082_0044;
	localparam logic [31:0] ADDR_CH1_LEFT      = 32'h8082_0048;
	localparam logic [31:0] ADDR_CH1_RIGHT     = 32'h8082_004C;
	localparam logic [31:0] ADDR_CH2_LEFT      = 32'h8082_0050;
	localparam logic [31:0] ADDR_CH2_RIGHT     = 32'h8082_0054;
	localparam logic [31:0] ADDR_LINE_FORMAT   = 32'h8082_0058;
	localparam logic [31:0] ADDR_IRQ_SETUP     = 32'h8082_005C;
	localparam logic [31:0] ADDR_WORD_SIZE     = 32'h8082_0060;
	localparam logic [31:0] ADDR_CH0_ON        = 32'h8082_0064;
	localparam logic [31:0] ADDR_CH1_ON        = 32'h8082_0068;
	localparam logic [31:0] ADDR_CH2_ON        = 32'h8082_006C;

	// Field positions.
	localparam int LF_SHIFT_ORDER = 0;
	localparam int LF_JUSTIFY     = 1;
	localparam int IS_THRESHOLD   = 0;
	localparam int IS_IRQ_ON      = 1;
	localparam int CK_LRS         = 0;
	localparam int CK_CKP         = 1;
	localparam int CK_REL         = 2;
	localparam int CK_MSTR        = 3;
	localparam int CK_NBCG        = 4;
	localparam int CK_BCR_LO      = 5;

	// Reset values.
	localparam logic [1:0] LINE_FORMAT_RST = 2'h0;
	localparam logic [1:0] IRQ_SETUP_RST   = 2'h0;
	localparam logic [1:0] WORD_SIZE_RST   = 2'h0;
	localparam logic [2:0] CHAN_ON_RST     = 3'h0;
	localparam logic [6:0] CLOCK_SETUP_RST = 7'h00;
	localparam logic [31:0] SAMPLE_RST     = 32'h0000_0000;

	// Word size codes and bit-clock rate codes.
	localparam logic [1:0] WS_16   = 2'h0;
	localparam logic [1:0] WS_24   = 2'h1;
	localparam logic [1:0] WS_32   = 2'h2;
	localparam logic [1:0] BCR_WL  = 2'h0;
	localparam logic [1:0] BCR_32X = 2'h1;
	localparam logic [1:0] BCR_64X = 2'h2;

	// Bits per word slot for each rate, then bits per word for each word size.
	localparam logic [6:0] SLOT_32X  = 7'h10;
	localparam logic [6:0] SLOT_64X  = 7'h20;
	localparam logic [6:0] SLOT_128X = 7'h40;
	localparam logic [6:0] BITS_16   = 7'h10;
	localparam logic [6:0] BITS_24   = 7'h18;
	localparam logic [6:0] BITS_32   = 7'h20;

	localparam int SAMPLE_SLOTS = 6;
	localparam int CHANNELS     = 3;

	typedef enum logic [0:0]
	{
		ST_IDLE    = 1'b0,
		ST_CAPTURE = 1'b1
	} i2r_state_t;

	// One received word on its way to a sample register.
	typedef struct packed
	{
		logic        side;
		logic [31:0] data;
	} i2r_word_t;

endpackage : i2r_pkg

// ---- rtl/i2r_fifo.sv ----
`timescale 1ns/1ps

module i2r_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 4
)(
	// Clock and reset.
	input  wire logic                     clk_sys,
	input  wire logic                     reset_n,
	// Fill side.
	input  wire logic                     in_valid,
	output      logic                     in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	// Drain side.
	output      logic                     out_valid,
	input  wire logic                     out_ready,
	output      logic [WIDTH-1:0]         out_data,
	// Fill level.
	output      logic [$clog2(DEPTH):0]   level
);

	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH)
		begin : g_bad_depth
			$error("i2r_fifo depth must be a power of two of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = (level != DEPTH[AW:0]);
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				level <= level + 1'b1;
			else if (pop && !push)
				level <= level - 1'b1;
		end
	end

endmodule : i2r_fifo

// ---- rtl/i2r_receiver.sv ----
`timescale 1ns/1ps

module i2r_receiver #(
	parameter int FIFO_DEPTH = 4
)(
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	// DMA read port for the sample registers.
	input  wire logic        dma_rd_req,
	input  wire logic [2:0]  dma_rd_slot,
	output      logic        dma_rd_ack,
	output      logic [31:0] dma_rd_data,
	output      logic [5:0]  dma_slot_ready,
	// Serial audio inputs.
	input  wire logic        rx_bit_clk,
	input  wire logic        rx_frame_sel,
	input  wire logic [2:0]  rx_serial_data,
	// Interrupt.
	output      logic        rx_irq
);

	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	generate
		if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH)
		begin : g_bad_depth
			$error("i2r_receiver FIFO_DEPTH must be a power of two of at least 2");
		end
	endgenerate

	function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic d, input logic lsb_first);
		shift_in = lsb_first ? {d, sh[31:1]} : {sh[30:0], d};
	endfunction : shift_in

	// The shift register holds the word low-aligned for MSB-first and high-aligned for LSB-first.
	function automatic logic [31:0] justify(input logic [31:0] sh, input logic [6:0] n,
		input logic lsb_first, input logic right);
		logic [5:0] pad;
		pad = 6'((7'h20 - n) & 7'h1F);
		if (n >= 7'h20)
			justify = sh;
		else if (lsb_first)
			justify = right ? (sh >> pad) : sh;
		else
			justify = right ? sh : (sh << pad);
	endfunction : justify

	function automatic logic [6:0] word_bits(input logic [1:0] ws);
		case (ws)
			i2r_pkg::WS_16: word_bits = i2r_pkg::BITS_16;
			i2r_pkg::WS_24: word_bits = i2r_pkg::BITS_24;
			default:        word_bits = i2r_pkg::BITS_32;
		endcase
	endfunction : word_bits

	// Registers.
	logic [1:0]  line_format;
	logic [1:0]  irq_setup;
	logic [1:0]  word_size;
	logic [2:0]  chan_on;
	logic [6:0]  clock_setup;
	logic [31:0] sample [i2r_pkg::SAMPLE_SLOTS];
	logic [5:0]  slot_full;

	// Configuration fields.
	logic       rx_shift_order;
	logic       left_right_justify;
	logic       rx_irq_on;
	logic       rx_fill_irq_threshold;
	logic [1:0] word_size_field;
	logic       frame_early;
	logic       clock_falling;
	logic       frame_swap;
	logic [1:0] rate_field;
	logic [6:0] slot_bits;
	logic [6:0] bit_limit;

	assign rx_shift_order        = line_format[i2r_pkg::LF_SHIFT_ORDER];
	assign left_right_justify    = line_format[i2r_pkg::LF_JUSTIFY];
	assign rx_irq_on             = irq_setup[i2r_pkg::IS_IRQ_ON];
	assign rx_fill_irq_threshold = irq_setup[i2r_pkg::IS_THRESHOLD];
	assign word_size_field       = word_size;
	assign frame_early           = clock_setup[i2r_pkg::CK_REL];
	assign clock_falling         = clock_setup[i2r_pkg::CK_CKP];
	assign frame_swap            = clock_setup[i2r_pkg::CK_LRS];
	assign rate_field            = clock_setup[i2r_pkg::CK_BCR_LO+1:i2r_pkg::CK_BCR_LO];

	// A fixed rate sets the slot length; the word length then only limits captured bits.
	always_comb
	begin
		case (rate_field)
			i2r_pkg::BCR_32X: slot_bits = i2r_pkg::SLOT_32X;
			i2r_pkg::BCR_64X: slot_bits = i2r_pkg::SLOT_64X;
			i2r_pkg::BCR_WL:  slot_bits = (word_size_field == i2r_pkg::WS_16) ? i2r_pkg::SLOT_32X
				: i2r_pkg::SLOT_64X;
			default:          slot_bits = i2r_pkg::SLOT_128X;
		endcase
		bit_limit = (word_bits(word_size_field) < slot_bits) ? word_bits(word_size_field) : slot_bits;
	end

	// Bit-clock edge detection; the pins are taken as synchronous to clk_sys.
	logic bclk_prev;
	logic fs_prev;
	logic sample_edge;
	logic fs_change;
	i2r_pkg::i2r_state_t state;
	logic [6:0] bit_cnt;
	logic       take;

	assign sample_edge = clock_falling ? (bclk_prev & ~rx_bit_clk) : (~bclk_prev & rx_bit_clk);
	assign fs_change   = sample_edge & (rx_frame_sel != fs_prev);
	assign take        = (state == i2r_pkg::ST_CAPTURE) && (bit_cnt < bit_limit);

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			bclk_prev <= 1'b0;
			fs_prev   <= 1'b0;
		end
		else
		begin
			bclk_prev <= rx_bit_clk;
			if (sample_edge)
				fs_prev <= rx_frame_sel;
		end
	end

	// With early framing the changing edge still carries the last bit of the old word.
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			state   <= i2r_pkg::ST_IDLE;
			bit_cnt <= 7'h00;
		end
		else if (fs_change)
		begin
			state   <= i2r_pkg::ST_CAPTURE;
			bit_cnt <= frame_early ? 7'h00 : 7'h01;
		end
		else if (sample_edge && take)
		begin
			bit_cnt <= bit_cnt + 7'h01;
		end
	end

	// Per-channel shifting, word completion and FIFO.
	logic [31:0]            shreg [i2r_pkg::CHANNELS];
	logic [2:0]             push_valid;
	logic [2:0]             push_ready;
	i2r_pkg::i2r_word_t     push_word [i2r_pkg::CHANNELS];
	logic [2:0]             pop_valid;
	logic [2:0]             pop_ready;
	i2r_pkg::i2r_word_t     pop_word [i2r_pkg::CHANNELS];
	logic [LW-1:0]          fill [i2r_pkg::CHANNELS];
	logic [2:0]             fill_hit;

	for (genvar c = 0; c < i2r_pkg::CHANNELS; c++)
	begin : g_chan
		logic        take_old;
		logic [31:0] old_sh;
		logic [6:0]  old_n;
		logic [2:0]  slot_idx;

		assign take_old = take & (~fs_change | frame_early);
		assign old_sh   = take_old ? shift_in(shreg[c], rx_serial_data[c], rx_shift_order) : shreg[c];
		assign old_n    = bit_cnt + {6'h00, take_old};

		// Words finish on a frame-select change; a full FIFO drops the new word.
		assign push_valid[c]     = fs_change && (state == i2r_pkg::ST_CAPTURE) && chan_on[c] && (old_n != 7'h00);
		assign push_word[c].side = fs_prev ^ frame_swap;
		assign push_word[c].data = justify(old_sh, old_n, rx_shift_order, left_right_justify);

		always_ff @(posedge clk_sys)
		begin
			if (!reset_n)
				shreg[c] <= 32'h0000_0000;
			else if (fs_change)
				shreg[c] <= frame_early ? 32'h0000_0000
					: shift_in(32'h0000_0000, rx_serial_data[c], rx_shift_order);
			else if (sample_edge && take)
				shreg[c] <= shift_in(shreg[c], rx_serial_data[c], rx_shift_order);
		end

		i2r_fifo #(
			.WIDTH ($bits(i2r_pkg::i2r_word_t)),
			.DEPTH (FIFO_DEPTH)
		) u_fifo (
			.clk_sys   (clk_sys),
			.reset_n   (reset_n),
			.in_valid  (push_valid[c]),
			.in_ready  (push_ready[c]),
			.in_data   (push_word[c]),
			.out_valid (pop_valid[c]),
			.out_ready (pop_ready[c]),
			.out_data  (pop_word[c]),
			.level     (fill[c])
		);

		// The FIFO drains only into an empty sample register, so it fills when software lags.
		assign slot_idx     = 3'(2 * c) + {2'b00, pop_word[c].side};
		assign pop_ready[c] = ~slot_full[slot_idx];
		assign fill_hit[c]  = rx_fill_irq_threshold ? (fill[c] == LW'(FIFO_DEPTH))
			: (fill[c] >= LW'(FIFO_DEPTH / 2));
	end

	// APB decode.
	logic apb_setup;
	logic apb_access;
	logic is_sample;
	logic is_ctrl;
	logic [2:0] apb_slot;

	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable;
	assign is_sample  = (paddr >= i2r_pkg::ADDR_CH0_LEFT) && (paddr <= i2r_pkg::ADDR_CH2_RIGHT) && (paddr[1:0] == 2'h0);
	assign is_ctrl    = (paddr == i2r_pkg::ADDR_LINE_FORMAT) || (paddr == i2r_pkg::ADDR_IRQ_SETUP)
		|| (paddr == i2r_pkg::ADDR_WORD_SIZE) || (paddr == i2r_pkg::ADDR_CH0_ON)
		|| (paddr == i2r_pkg::ADDR_CH1_ON) || (paddr == i2r_pkg::ADDR_CH2_ON)
		|| (paddr == i2r_pkg::ADDR_CLOCK_SETUP);
	assign apb_slot   = 3'((paddr - i2r_pkg::ADDR_CH0_LEFT) >> 2);
	assign pready     = 1'b1;
	assign pslverr    = apb_access & ~is_ctrl & ~(is_sample & ~pwrite);

	// Control registers take writes from APB only.
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			line_format <= i2r_pkg::LINE_FORMAT_RST;
			irq_setup   <= i2r_pkg::IRQ_SETUP_RST;
			word_size   <= i2r_pkg::WORD_SIZE_RST;
			chan_on     <= i2r_pkg::CHAN_ON_RST;
			clock_setup <= i2r_pkg::CLOCK_SETUP_RST;
		end
		else if (apb_access && pwrite)
		begin
			case (paddr)
				i2r_pkg::ADDR_LINE_FORMAT: line_format <= pwdata[1:0];
				i2r_pkg::ADDR_IRQ_SETUP:   irq_setup   <= pwdata[1:0];
				i2r_pkg::ADDR_WORD_SIZE:   word_size   <= pwdata[1:0];
				i2r_pkg::ADDR_CH0_ON:      chan_on[0]  <= pwdata[0];
				i2r_pkg::ADDR_CH1_ON:      chan_on[1]  <= pwdata[0];
				i2r_pkg::ADDR_CH2_ON:      chan_on[2]  <= pwdata[0];
				i2r_pkg::ADDR_CLOCK_SETUP: clock_setup <= pwdata[6:0];
				default:                   line_format <= line_format;
			endcase
		end
	end

	// Read data is fetched in the setup phase so it stands in a flip-flop for the access phase.
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			prdata <= 32'h0000_0000;
		else if (apb_setup)
		begin
			if (is_sample)
				prdata <= sample[apb_slot];
			else
			begin
				case (paddr)
					i2r_pkg::ADDR_LINE_FORMAT: prdata <= {30'h0000_0000, line_format};
					i2r_pkg::ADDR_IRQ_SETUP:   prdata <= {30'h0000_0000, irq_setup};
					i2r_pkg::ADDR_WORD_SIZE:   prdata <= {30'h0000_0000, word_size};
					i2r_pkg::ADDR_CH0_ON:      prdata <= {31'h0000_0000, chan_on[0]};
					i2r_pkg::ADDR_CH1_ON:      prdata <= {31'h0000_0000, chan_on[1]};
					i2r_pkg::ADDR_CH2_ON:      prdata <= {31'h0000_0000, chan_on[2]};
					i2r_pkg::ADDR_CLOCK_SETUP: prdata <= {25'h000_0000, clock_setup};
					default:                   prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// DMA sees only the six sample registers.
	logic dma_ok;

	assign dma_ok = dma_rd_slot < 3'(i2r_pkg::SAMPLE_SLOTS);

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			dma_rd_ack  <= 1'b0;
			dma_rd_data <= 32'h0000_0000;
		end
		else
		begin
			dma_rd_ack  <= dma_rd_req;
			dma_rd_data <= (dma_rd_req && dma_ok) ? sample[dma_rd_slot] : 32'h0000_0000;
		end
	end

	// Sample registers load from the FIFOs; a load in the same cycle as a read keeps the slot full.
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			for (int s = 0; s < i2r_pkg::SAMPLE_SLOTS; s++)
				sample[s] <= i2r_pkg::SAMPLE_RST;
			slot_full <= 6'h00;
		end
		else
		begin
			for (int s = 0; s < i2r_pkg::SAMPLE_SLOTS; s++)
			begin
				if (pop_valid[s/2] && pop_ready[s/2] && (pop_word[s/2].side == 1'(s % 2)))
				begin
					sample[s]    <= pop_word[s/2].data;
					slot_full[s] <= 1'b1;
				end
				else if ((apb_access && !pwrite && is_sample && apb_slot == 3'(s))
					|| (dma_rd_req && dma_rd_slot == 3'(s)))
					slot_full[s] <= 1'b0;
			end
		end
	end

	assign dma_slot_ready = slot_full;

	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
			rx_irq <= 1'b0;
		else
			rx_irq <= rx_irq_on & (|fill_hit);
	end

endmodule : i2r_receiver

// ---- verif/i2r_receiver_assertions.sv ----
`timescale 1ns/1ps

module i2r_receiver_assertions #(
	parameter int FIFO_DEPTH = 4
)(
	// Clock and reset.
	input wire logic        clk_sys,
	input wire logic        reset_n,
	// APB.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// DMA.
	input wire logic        dma_rd_req,
	input wire logic [2:0]  dma_rd_slot,
	input wire logic        dma_rd_ack,
	input wire logic [31:0] dma_rd_data,
	input wire logic [5:0]  dma_slot_ready,
	// Serial lines and interrupt.
	input wire logic        rx_bit_clk,
	input wire logic        rx_frame_sel,
	input wire logic [2:0]  rx_serial_data,
	input wire logic        rx_irq
);
	logic [1:0] lf_copy;
	logic       irq_on_copy;
	logic       ch2_on_copy;
	wire        wr  = psel && penable && pwrite;
	wire        rd  = psel && penable && !pwrite;
	wire        smp = paddr >= i2r_pkg::ADDR_CH0_LEFT && paddr <= i2r_pkg::ADDR_CH2_RIGHT;

	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// Shadows of written fields, since the registers themselves are not visible here.
	always_ff @(posedge clk_sys)
	begin
		if (!reset_n)
		begin
			lf_copy <= 2'h0;
			irq_on_copy <= 1'h0;
			ch2_on_copy <= 1'h0;
		end
		else if (wr)
		begin
			if (paddr == i2r_pkg::ADDR_LINE_FORMAT)
				lf_copy <= pwdata[1:0];
			if (paddr == i2r_pkg::ADDR_IRQ_SETUP)
				irq_on_copy <= pwdata[1];
			if (paddr == i2r_pkg::ADDR_CH2_ON)
				ch2_on_copy <= pwdata[0];
		end
	end

	property p_ack_follows;
		dma_rd_req |=> dma_rd_ack;
	endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("dma ack missing");
	property p_no_stray_ack;
		!dma_rd_req |=> !dma_rd_ack;
	endproperty
	a_no_stray_ack: assert property (p_no_stray_ack) else $error("dma ack without request");
	property p_slot_beyond;
		dma_rd_req && dma_rd_slot > 3'h5 |=> dma_rd_data == 32'h0;
	endproperty
	a_slot_beyond: assert property (p_slot_beyond) else $error("dma reached a control place");
	property p_sample_write_err;
		wr && smp |-> pslverr;
	endproperty
	a_sample_write_err: assert property (p_sample_write_err) else $error("sample write accepted");
	property p_sample_read_ok;
		rd && smp |-> !pslverr;
	endproperty
	a_sample_read_ok: assert property (p_sample_read_ok) else $error("sample read refused");
	property p_irq_gated;
		!irq_on_copy && !$past(irq_on_copy) |-> !rx_irq;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("interrupt while disabled");
	property p_format_readback;
		rd && paddr == i2r_pkg::ADDR_LINE_FORMAT |-> prdata == {30'h0, lf_copy} && !pslverr;
	endproperty
	a_format_readback: assert property (p_format_readback) else $error("line format readback");
	property p_enable_readback;
		rd && paddr == i2r_pkg::ADDR_CH2_ON |-> prdata == {31'h0, ch2_on_copy};
	endproperty
	a_enable_readback: assert property (p_enable_readback) else $error("enable readback");
	property p_reset_clean;
		!$past(reset_n) |-> (!rx_irq && dma_slot_ready == 6'h00)[*3];
	endproperty
	a_reset_clean: assert property (p_reset_clean) else $error("state after reset");

	c_irq: cover property ($rose(rx_irq));
	c_dma: cover property (dma_rd_ack && dma_rd_data != 32'h0);
	c_err: cover property (pslverr && pwrite);
endmodule : i2r_receiver_assertions

bind i2r_receiver i2r_receiver_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) i2r_receiver_assertions_inst (
	.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.dma_rd_req, .dma_rd_slot, .dma_rd_ack, .dma_rd_data, .dma_slot_ready,
	.rx_bit_clk, .rx_frame_sel, .rx_serial_data, .rx_irq
);

// ---- verif/i2r_audio_src.sv ----
`timescale 1ns/1ps

module i2r_audio_src (
	// Paces the bit clock.
	input  wire logic       clk_sys,
	// Serial lines.
	output      logic       rx_bit_clk,
	output      logic       rx_frame_sel,
	output      logic [2:0] rx_serial_data
);
	initial
	begin
		rx_bit_clk = 1'h0;
		rx_frame_sel = 1'h1;
		rx_serial_data = 3'h5;
	end

	// Sends one word slot per channel, first bit at pat[31]; the bit clock stops afterwards.
	// Lines change on the edge to level pol; early moves the frame change onto the last bit.
	task automatic send_word(input logic [31:0] pat [3], input int slot, input logic pol, input logic early);
		for (int i = 0; i < slot; i++)
		begin
			repeat (2) @(posedge clk_sys);
			rx_bit_clk <= pol;
			if (early ? (i == slot - 1) : (i == 0))
				rx_frame_sel <= !rx_frame_sel;
			for (int c = 0; c < 3; c++)
				rx_serial_data[c] <= pat[c][31 - i];
			repeat (2) @(posedge clk_sys);
			rx_bit_clk <= !pol;
		end
		repeat (2) @(posedge clk_sys);
		rx_bit_clk <= pol;
		// A stale bit must not pass for a held one.
		rx_serial_data <= ~rx_serial_data;
	endtask : send_word
endmodule : i2r_audio_src

// ---- verif/i2r_receiver_tb.sv ----
`timescale 1ns/1ps

module i2r_receiver_tb;
	logic        clk_sys;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        dma_rd_req;
	logic [2:0]  dma_rd_slot;
	logic        dma_rd_ack;
	logic [31:0] dma_rd_data;
	logic [5:0]  dma_slot_ready;
	logic        rx_bit_clk;
	logic        rx_frame_sel;
	logic [2:0]  rx_serial_data;
	logic        rx_irq;
	logic [31:0] rq;
	logic        re;
	int          fails = 0;
	int          tests_run = 0;

	i2r_receiver #(.FIFO_DEPTH(4)) i2r_receiver_inst (
		.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.dma_rd_req, .dma_rd_slot, .dma_rd_ack, .dma_rd_data, .dma_slot_ready,
		.rx_bit_clk, .rx_frame_sel, .rx_serial_data, .rx_irq
	);
	i2r_audio_src i2r_audio_src_inst (.clk_sys, .rx_bit_clk, .rx_frame_sel, .rx_serial_data);

	initial
	begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Index 0..5 samples, 6 line format, 7 interrupt setup, 8 word size, 9..11 channel enables.
	function automatic logic [31:0] ra(input int k);
		return i2r_pkg::ADDR_CH0_LEFT + 32'(4 * k);
	endfunction : ra

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// The idle edge at the end keeps back-to-back calls from driving psel twice at one edge.
	task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		@(posedge clk_sys);
		rq = prdata;
		re = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_sys);
	endtask : apb

	task automatic dma(input logic [2:0] s);
		dma_rd_req <= 1'h1;
		dma_rd_slot <= s;
		@(posedge clk_sys);
		dma_rd_req <= 1'h0;
		@(posedge clk_sys);
		rq = dma_rd_data;
		check({31'h0, dma_rd_ack}, 32'h1);
		repeat (2) @(posedge clk_sys);
	endtask : dma

	task automatic t_reset_values();
		for (int k = 0; k < 12; k++)
		begin
			apb(ra(k), 1'h0, 32'h0);
			check(rq, 32'h0);
		end
		apb(ra(3), 1'h1, 32'h0);
		check({31'h0, re}, 32'h1);
		apb(ra(8), 1'h1, 32'h3);
		apb(ra(8), 1'h0, 32'h0);
		check(rq, 32'h3);
		apb(ra(11), 1'h1, 32'h1);
		apb(ra(11), 1'h0, 32'h0);
		check(rq, 32'h1);
		apb(ra(8), 1'h1, 32'h0);
		apb(ra(11), 1'h1, 32'h0);
		apb(ra(12), 1'h0, 32'h0);
		check({rq[30:0], re}, 32'h1);
		check({31'h0, pready}, 32'h1);
		dma(3'h6);
		check(rq, 32'h0);
	endtask : t_reset_values

	task automatic t_disabled_drop();
		logic [31:0] p [3];
		p = '{32'hA1B2_C3D4, 32'h5E6F_7081, 32'h9293_9495};
		repeat (2) i2r_audio_src_inst.send_word(p, 16, 1'h0, 1'h0);
		check({26'h0, dma_slot_ready}, 32'h0);
	endtask : t_disabled_drop

	// Three like words; the word in flight before the change is read out and dropped.
	task automatic t_format(input logic [1:0] ws, input logic [1:0] lf, input logic [6:0] ck);
		logic [31:0] p [3];
		logic [31:0] x [3];
		int n;
		int slot;
		int s;
		slot = ck[6:5] == 2'h0 ? (ws == 2'h0 ? 16 : 32) : 8 << ck[6:5];
		n = ws == 2'h0 ? 16 : ws == 2'h1 ? 24 : 32;
		n = n < slot ? n : slot;
		apb(ra(6), 1'h1, {30'h0, lf});
		apb(ra(8), 1'h1, {30'h0, ws});
		apb(i2r_pkg::ADDR_CLOCK_SETUP, 1'h1, {25'h0, ck});
		for (int c = 0; c < 3; c++)
		begin
			apb(ra(9 + c), 1'h1, 32'h1);
			x[c] = (32'hC35A_96E1 ^ (32'h1111_1111 << c)) & (32'hFFFF_FFFF >> (32 - n));
			for (int i = 0; i < 32; i++)
				p[c][31 - i] = i >= n ? i[0] : lf[0] ? x[c][i] : x[c][n - 1 - i];
			x[c] = lf[1] ? x[c] : x[c] << (32 - n);
		end
		i2r_audio_src_inst.send_word(p, slot, ck[1], ck[2]);
		s = rx_frame_sel ^ ck[0];
		repeat (2) i2r_audio_src_inst.send_word(p, slot, ck[1], ck[2]);
		for (int c = 0; c < 3; c++)
		begin
			apb(ra(2 * c + s), 1'h0, 32'h0);
			check(rq, x[c]);
			dma(3'(2 * c + 1 - s));
			dma(3'(2 * c + 1 - s));
			check(rq, x[c]);
		end
		check({26'h0, dma_slot_ready}, 32'h0);
	endtask : t_format

	task automatic t_irq();
		logic [31:0] p [3];
		p = '{32'h1234_5678, 32'h9ABC_DEF0, 32'h0F1E_2D3C};
		repeat (5) i2r_audio_src_inst.send_word(p, 16, 1'h0, 1'h0);
		check({31'h0, rx_irq}, 32'h0);
		apb(ra(7), 1'h1, 32'h2);
		repeat (2) @(posedge clk_sys);
		check({31'h0, rx_irq}, 32'h1);
		apb(ra(7), 1'h1, 32'h3);
		repeat (2) @(posedge clk_sys);
		check({31'h0, rx_irq}, 32'h0);
		repeat (4) i2r_audio_src_inst.send_word(p, 16, 1'h0, 1'h0);
		check({31'h0, rx_irq}, 32'h1);
		for (int k = 0; k < 6; k++)
			dma(3'(k));
		repeat (2) @(posedge clk_sys);
		check({31'h0, rx_irq}, 32'h0);
	endtask : t_irq

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	initial
	begin
		reset_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 32'h0;
		pwdata = 32'h0;
		dma_rd_req = 1'h0;
		dma_rd_slot = 3'h0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'h1;
		@(posedge clk_sys);
		t_reset_values();
		t_disabled_drop();
		t_format(2'h0, 2'h0, 7'h00);
		t_format(2'h1, 2'h3, 7'h01);
		t_format(2'h2, 2'h1, 7'h00);
		t_format(2'h0, 2'h1, 7'h06);
		t_format(2'h0, 2'h2, 7'h40);
		t_format(2'h2, 2'h0, 7'h20);
		t_irq();
		give_verdict();
	end

	// The planned run is near 3000 cycles; this leaves ample margin.
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		fails++;
		give_verdict();
	end
endmodule : i2r_receiver_tb
